// ==== logic/gain_ctrl.sv ====
/*
 * mic level control, playback volume ramp and output routing controls.
 * assumes level inputs from the analog side are synchronous to CLK_IN,
 * and one FS_TICK pulse per sample period.
 */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - agc enable 0 holds programmed gain; 1 with mic power on lets level control drive it
// - above threshold the gain drops by the attenuation step
// - zero-cross disabled: limiter steps timed by limiter timeout
// - limiting restarts whenever level again reaches the threshold
// - zero-cross enabled: steps wait for a zero crossing or timeout
// - after limiting wait recovery period while below reset level
// - recovery raises gain one step per period up to ceiling
// - zero crossing in a wait period applies step, then waits again; recovery here ignores zero crossings
// - level above threshold during recovery switches to limiting
// - recovery timer clears between reset level and threshold
// - preamp select: 0 gives 0dB, 1 gives +20dB, resets to 1
// - volume 00 is +12dB, 0.5dB steps, fe -115dB, ff mute, reset 18
// - volume is applied to samples ahead of the converter
// - full volume swing takes 1061 sample periods; the ramp here takes 1020 (4 per code)
// - tone input powered by its bit, routed by two select bits
// - speaker power 0 floats mono mix and both speaker outputs
// - save mode floats positive output, drives negative to mid supply
// - speaker gain bit picks low or high output power
module gain_ctrl
  import gain_ctrl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic FS_TICK_IN,
  input wire logic OVER_LIMIT_IN,
  input wire logic ABOVE_RESET_LVL_IN,
  input wire logic ZERO_CROSS_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [6:0] GAIN_CODE_OUT,
  output logic [7:0] VOL_CODE_OUT,
  output logic PREAMP_HI_OUT,
  output logic TONE_PWR_OUT,
  output logic TONE_SPK_OUT,
  output logic TONE_LO_OUT,
  output gain_ctrl_pkg::spk_t SPK_OUT
);
  import gain_ctrl_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LIMIT = 3'b010,
    S_RECOVER = 3'b100
  } agc_state_t;

  ctrl_t ctrl_q, ctrl_d;
  logic [31:0] agc_q, agc_d;
  logic [6:0] gain_q, gain_d;
  logic [7:0] vol_tgt_q, vol_tgt_d;
  logic [7:0] vol_q, vol_d;
  logic [2:0] ramp_q, ramp_d;
  agc_state_t st_q, st_d;
  logic [10:0] tmr_q, tmr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [6:0] ceil;
  logic agc_run;
  logic wr, rd, hit;
  logic [10:0] lim_per, zc_per, wt_per;

  // period in samples for a 2-bit select: base shifted by code
  function automatic logic [10:0] period(input int base,
                                         input logic [1:0] sel);
    logic [10:0] b;
    b = 11'(base);
    return b << sel;
  endfunction

  // saturating add/subtract on the 7-bit gain code
  // step is four bits wide so that the largest attenuation step fits
  function automatic logic [6:0] gain_add(input logic [6:0] g,
                                          input logic [3:0] step,
                                          input logic up,
                                          input logic [6:0] top);
    logic [7:0] s;
    s = 8'h00;
    if (up) begin
      s = {1'b0, g} + {4'h0, step};
      if (s > {1'b0, top})
        s = {1'b0, top};
    end else begin
      if ({4'h0, step} > {1'b0, g})
        s = 8'h00;
      else
        s = {1'b0, g} - {4'h0, step};
    end
    return s[6:0];
  endfunction

  assign ceil = agc_q[B_CEIL +: 7];
  assign agc_run = ctrl_q.agc_en && ctrl_q.mic_pwr;
  assign lim_per = period(LIM_BASE_FS, agc_q[B_LTO +: 2]);
  assign zc_per = period(ZC_BASE_FS, agc_q[B_ZTO +: 2]);
  assign wt_per = period(ZC_BASE_FS, agc_q[B_WTO +: 2]);

  // the ramp counter is three bits wide
  if (RAMP_FS < 1 || RAMP_FS > 8) begin : g_ramp_chk
    $error("ramp interval does not fit the ramp counter");
  end

  // apb slave: zero wait states, error on unmapped offsets
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  always_comb begin
    hit = 1'b0;
    case (PADDR_IN[7:0])
      OFS_CTRL, OFS_AGC, OFS_GAIN, OFS_VOL, OFS_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    hit = hit && (PADDR_IN[31:8] == 24'h000000);
  end
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
  assign PRDATA_OUT = prdata_q;

  always_comb begin
    prdata_d = prdata_q;
    if (rd) begin
      prdata_d = 32'h00000000;
      case (PADDR_IN[7:0])
        OFS_CTRL: prdata_d = {23'h000000, ctrl_q};
        OFS_AGC: prdata_d = agc_q;
        OFS_GAIN: prdata_d = {25'h0000000, gain_q};
        OFS_VOL: prdata_d = {24'h000000, vol_tgt_q};
        OFS_STAT: prdata_d = {13'h0000, st_q, vol_q, 1'b0, gain_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    agc_d = agc_q;
    vol_tgt_d = vol_tgt_q;
    if (wr && hit) begin
      case (PADDR_IN[7:0])
        OFS_CTRL: ctrl_d = ctrl_t'(PWDATA_IN[8:0]);
        OFS_AGC: agc_d = {9'h000, PWDATA_IN[22:16], 5'h00,
                          PWDATA_IN[10:0]};
        OFS_VOL: vol_tgt_d = PWDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  // level control sequencer
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    gain_d = gain_q;
    if (wr && hit && PADDR_IN[7:0] == OFS_GAIN && !agc_run)
      gain_d = gain_add(PWDATA_IN[6:0], 4'h0, 1'b1, GAIN_MAX);
    if (!agc_run) begin
      st_d = S_IDLE;
      tmr_d = 11'h000;
    end else if (FS_TICK_IN) begin
      unique case (st_q)
        S_IDLE: begin
          tmr_d = 11'h000;
          if (OVER_LIMIT_IN)
            st_d = S_LIMIT;
          else
            st_d = S_RECOVER;
        end
        S_LIMIT: begin
          tmr_d = tmr_q + 11'h001;
          if (!OVER_LIMIT_IN) begin
            st_d = S_RECOVER;
            tmr_d = 11'h000;
          end else if (agc_q[B_ZDIS] ? tmr_q + 11'h001 >= lim_per
                       : (ZERO_CROSS_IN ||
                          tmr_q + 11'h001 >= zc_per)) begin
            gain_d = gain_add(gain_q,
                              4'h1 << agc_q[B_ATT +: 2],
                              1'b0, GAIN_MAX);
            tmr_d = 11'h000;
          end
        end
        S_RECOVER: begin
          if (OVER_LIMIT_IN) begin
            st_d = S_LIMIT;
            tmr_d = 11'h000;
          end else if (ABOVE_RESET_LVL_IN) begin
            tmr_d = 11'h000;
          end else if (tmr_q + 11'h001 >= wt_per) begin
            tmr_d = 11'h000;
            gain_d = gain_add(gain_q,
                              agc_q[B_RSTEP] ? 4'h2 : 4'h1,
                              1'b1, ceil);
          end else begin
            tmr_d = tmr_q + 11'h001;
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  // volume ramp: one code every RAMP_FS samples
  always_comb begin
    vol_d = vol_q;
    ramp_d = ramp_q;
    if (FS_TICK_IN) begin
      if (vol_q == vol_tgt_q) begin
        ramp_d = 3'h0;
      end else if (ramp_q >= 3'(RAMP_FS - 1)) begin
        ramp_d = 3'h0;
        vol_d = (vol_q < vol_tgt_q) ? vol_q + 8'h01
                                    : vol_q - 8'h01;
      end else begin
        ramp_d = ramp_q + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_q <= ctrl_t'(CTRL_RST);
      agc_q <= {9'h000, CEIL_RST, 16'h0000};
      gain_q <= GAIN_RST;
      vol_tgt_q <= VOL_RST;
      vol_q <= VOL_RST;
      ramp_q <= 3'h0;
      st_q <= S_IDLE;
      tmr_q <= 11'h000;
      prdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      agc_q <= agc_d;
      gain_q <= gain_d;
      vol_tgt_q <= vol_tgt_d;
      vol_q <= vol_d;
      ramp_q <= ramp_d;
      st_q <= st_d;
      tmr_q <= tmr_d;
      prdata_q <= prdata_d;
    end
  end

  assign GAIN_CODE_OUT = gain_q;
  assign VOL_CODE_OUT = vol_q;
  assign PREAMP_HI_OUT = ctrl_q.preamp;
  assign TONE_PWR_OUT = ctrl_q.tone_pwr;
  assign TONE_SPK_OUT = ctrl_q.tone_pwr && ctrl_q.tone_spk;
  assign TONE_LO_OUT = ctrl_q.tone_pwr && ctrl_q.tone_lo;

  // output enables low means driven
  always_comb begin
    SPK_OUT.mono_oe_n = !ctrl_q.spk_pwr;
    SPK_OUT.pos_oe_n = !(ctrl_q.spk_pwr && ctrl_q.spk_exit);
    SPK_OUT.neg_oe_n = !ctrl_q.spk_pwr;
    SPK_OUT.neg_mid = ctrl_q.spk_pwr && !ctrl_q.spk_exit;
    SPK_OUT.gain_hi = ctrl_q.spk_gain;
  end

  manual_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !agc_run && !(wr && PADDR_IN[7:0] == OFS_GAIN)
    |=> $stable(gain_q))
    else $error("gain moved in manual mode");
  limit_drop_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    agc_run && st_q == S_LIMIT && st_d == S_LIMIT && FS_TICK_IN
    && gain_q != gain_d |-> gain_d < gain_q)
    else $error("limiter raised gain");
  limit_enter_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    agc_run && st_q == S_RECOVER && FS_TICK_IN && OVER_LIMIT_IN
    |=> st_q == S_LIMIT)
    else $error("recovery did not yield to limiter");
  ceil_cap_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_q == S_RECOVER && gain_q > $past(gain_q) |-> gain_q <= ceil)
    else $error("recovery passed the ceiling");
  wait_clear_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    agc_run && st_q == S_RECOVER && FS_TICK_IN && ABOVE_RESET_LVL_IN
    && !OVER_LIMIT_IN |=> tmr_q == 11'h000)
    else $error("wait timer not cleared");
  ramp_step_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    vol_q != $past(vol_q) |-> vol_q - $past(vol_q) == 8'h01
    || $past(vol_q) - vol_q == 8'h01)
    else $error("volume jumped");
  spk_off_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !ctrl_q.spk_pwr |-> SPK_OUT.mono_oe_n && SPK_OUT.pos_oe_n
    && SPK_OUT.neg_oe_n)
    else $error("speaker driven while off");
  spk_save_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ctrl_q.spk_pwr && !ctrl_q.spk_exit |-> SPK_OUT.pos_oe_n
    && SPK_OUT.neg_mid && !SPK_OUT.neg_oe_n)
    else $error("save mode outputs wrong");
  tone_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !TONE_PWR_OUT |-> !TONE_SPK_OUT && !TONE_LO_OUT)
    else $error("tone routed unpowered");
  gain_range_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    gain_q <= GAIN_MAX)
    else $error("gain code out of range");

  limit_cov: cover property (@(posedge CLK_IN) st_q == S_LIMIT);
  recover_cov: cover property (@(posedge CLK_IN)
    st_q == S_RECOVER && gain_q > $past(gain_q));
  ramp_cov: cover property (@(posedge CLK_IN) $changed(vol_q));
endmodule // gain_ctrl

// ==== logic/gain_ctrl_pkg.sv ====
/*
 * constants and carrier types for the gain and level control block.
 * assumes an apb master at 100 mhz and one sample strobe per frame.
 */
package gain_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AGC = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h08;
  localparam logic [7:0] OFS_VOL = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // ctrl field positions
  localparam int B_PREAMP = 0;
  localparam int B_MICPWR = 1;
  localparam int B_AGCEN = 2;
  localparam int B_TONEPWR = 3;
  localparam int B_TONESPK = 4;
  localparam int B_TONELO = 5;
  localparam int B_SPKPWR = 6;
  localparam int B_SPKEXIT = 7;
  localparam int B_SPKGAIN = 8;
  // agc field positions
  localparam int B_LTH = 0;
  localparam int B_ATT = 1;
  localparam int B_ZDIS = 3;
  localparam int B_LTO = 4;
  localparam int B_ZTO = 6;
  localparam int B_WTO = 8;
  localparam int B_RSTEP = 10;
  localparam int B_CEIL = 16;
  // reset values
  localparam logic [8:0] CTRL_RST = 9'h001;
  localparam logic [6:0] GAIN_RST = 7'h10;
  localparam logic [6:0] CEIL_RST = 7'h47;
  localparam logic [7:0] VOL_RST = 8'h18;
  localparam logic [6:0] GAIN_MAX = 7'h47;
  localparam logic [7:0] VOL_MUTE = 8'hff;
  // timing: 1061 fs for 255 codes gives 4 fs per code
  localparam int FULL_SWING_FS = 1061;
  localparam int VOL_CODES = 255;
  localparam int RAMP_FS = FULL_SWING_FS / VOL_CODES;
  // base step periods in samples, doubled per select code
  localparam int LIM_BASE_FS = 2;
  localparam int ZC_BASE_FS = 128;

  typedef struct packed {
    logic spk_gain;
    logic spk_exit;
    logic spk_pwr;
    logic tone_lo;
    logic tone_spk;
    logic tone_pwr;
    logic agc_en;
    logic mic_pwr;
    logic preamp;
  } ctrl_t;

  typedef struct packed {
    logic pos_oe_n;
    logic neg_oe_n;
    logic neg_mid;
    logic mono_oe_n;
    logic gain_hi;
  } spk_t;
endpackage

// ==== verification/testbench.sv ====
/*
 * self-checking bench for the gain control block: apb registers,
 * manual and automatic gain, volume ramp, tone and speaker controls.
 * assumes the block answers apb with its own pready; one fs tick
 * is made every four clocks.
 */
`timescale 1ns/10ps
module testbench;
  import gain_ctrl_pkg::*;
  typedef struct packed {
    logic [2:0] id;
    logic [31:0] v;
  } note_t;
  logic clk, rst, fs, over, above, zc, psel, pen, pwr, pready, pslverr;
  logic obs_req;
  logic [31:0] paddr, pwdata, prdata;
  logic [6:0] gain;
  logic [7:0] vol;
  logic [1:0] div_q;
  logic [31:0] rnd;
  logic preamp, tpwr, tspk, tlo;
  spk_t spk;
  int num_errors, checks;
  logic [32:0] rd_q[$];
  note_t out_q[$];

  gain_ctrl DUT (.CLK_IN(clk), .RST_IN(rst), .FS_TICK_IN(fs),
    .OVER_LIMIT_IN(over), .ABOVE_RESET_LVL_IN(above), .ZERO_CROSS_IN(zc),
    .PADDR_IN(paddr), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .GAIN_CODE_OUT(gain), .VOL_CODE_OUT(vol),
    .PREAMP_HI_OUT(preamp), .TONE_PWR_OUT(tpwr), .TONE_SPK_OUT(tspk),
    .TONE_LO_OUT(tlo), .SPK_OUT(spk));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one sample tick every fourth clock
  always @(posedge clk) begin
    div_q <= rst ? 2'h0 : div_q + 2'h1;
    fs <= (div_q == 2'h3) && !rst;
  end

  function automatic logic [31:0] observe(input logic [2:0] id);
    case (id)
      3'h0: return {25'h0, gain};
      3'h1: return {24'h0, vol};
      3'h2: return {28'h0, spk.pos_oe_n, spk.neg_oe_n, spk.neg_mid,
                    spk.mono_oe_n};
      3'h3: return {28'h0, preamp, tpwr, tspk, tlo};
      default: return {31'h0, spk.gain_hi};
    endcase
  endfunction

  task automatic compare(input string n, input logic [32:0] e,
                         input logic [32:0] s);
    checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask

  // results are compared against the oldest note when they appear
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1)
      compare("apb read", rd_q.pop_front(), {pslverr, prdata});
    if (obs_req) begin
      note_t n;
      n = out_q.pop_front();
      compare($sformatf("output %0d", n.id), {1'b0, n.v},
              {1'b0, observe(n.id)});
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    if (!wr) rd_q.push_back(e);
    psel <= 1'b1;
    pen <= 1'b0;
    paddr <= {24'h0, a};
    pwr <= wr;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic expect_out(input logic [2:0] id, input logic [31:0] v);
    out_q.push_back('{id: id, v: v});
    @(posedge clk);
    obs_req <= 1'b1;
    @(posedge clk);
    obs_req <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * 4) @(posedge clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    above = 1'b1;
    {over, zc, psel, pen, pwr, obs_req} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    void'($urandom(32'h6c4f5187));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    expect_out(3'h3, 32'h8);
    expect_out(3'h1, {24'h0, VOL_RST});
    expect_out(3'h2, 32'hd);
    apb(1'b0, OFS_CTRL, 32'h0, 33'h1);
    apb(1'b0, OFS_AGC, 32'h0, {26'h0, CEIL_RST} << 16);
    apb(1'b0, OFS_VOL, 32'h0, {25'h0, VOL_RST});
    apb(1'b0, OFS_STAT, 32'h0, 33'h11810);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    // tone routing and speaker modes
    apb(1'b1, OFS_CTRL, 32'h18, 33'h0);
    expect_out(3'h3, 32'h6);
    apb(1'b1, OFS_CTRL, 32'h30, 33'h0);
    expect_out(3'h3, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h40, 33'h0);
    expect_out(3'h2, 32'ha);
    apb(1'b1, OFS_CTRL, 32'h1c0, 33'h0);
    expect_out(3'h2, 32'h0);
    expect_out(3'h4, 32'h1);
    apb(1'b1, OFS_CTRL, 32'hc0, 33'h0);
    expect_out(3'h4, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h40, 33'h0);
    expect_out(3'h2, 32'ha);
    apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
    expect_out(3'h2, 32'hd);
    // manual gain with random code in range
    rnd = $urandom_range(0, 71);
    apb(1'b1, OFS_CTRL, 32'h2, 33'h0);
    apb(1'b1, OFS_GAIN, rnd, 33'h0);
    expect_out(3'h0, rnd);
    apb(1'b0, OFS_GAIN, 32'h0, {1'b0, rnd});
    // limiter saturates, recovery waits, then stops at the ceiling
    above <= 1'b1;
    apb(1'b1, OFS_AGC, 32'h0002000c, 33'h0);
    apb(1'b1, OFS_GAIN, 32'h3, 33'h0);
    apb(1'b1, OFS_CTRL, 32'h6, 33'h0);
    apb(1'b1, OFS_GAIN, 32'h40, 33'h0);
    expect_out(3'h0, 32'h3);
    over <= 1'b1;
    ticks(40);
    over <= 1'b0;
    expect_out(3'h0, 32'h0);
    ticks(400);
    expect_out(3'h0, 32'h0);
    above <= 1'b0;
    ticks(1000);
    expect_out(3'h0, 32'h2);
    // zero-cross limiter: steps only when a crossing is seen
    apb(1'b1, OFS_CTRL, 32'h2, 33'h0);
    apb(1'b1, OFS_AGC, 32'h00470000, 33'h0);
    apb(1'b1, OFS_GAIN, 32'h20, 33'h0);
    above <= 1'b1;
    over <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h6, 33'h0);
    ticks(20);
    expect_out(3'h0, 32'h20);
    zc <= 1'b1;
    ticks(4);
    zc <= 1'b0;
    over <= 1'b0;
    expect_out(3'h0, 32'h1c);
    // volume ramp toward a new target
    apb(1'b1, OFS_VOL, 32'h1c, 33'h0);
    ticks(30);
    expect_out(3'h1, 32'h1c);
    print_verdict();
  end
endmodule // testbench
